// file: rtl/ulm_pkg.sv
// Purpose: Constants and types for the line and modem control block.
// Assumes: One channel, 8-bit registers, 3-bit register address.
// Notes: Rules below.
// Function
// RULE1 - Break bit forces serial output low until software clears it.
// RULE2 - Divisor access bit steers shared locations to the divisor latches.
// RULE3 - Terminal-ready bit drives its active-low output; reset leaves it high.
// RULE4 - Request-to-send bit drives its output unless hardware flow owns it.
// RULE5 - Interrupt pin floats when select input and enable bit are low.
// RULE6 - In loopback output-one feeds ring, enable bit drives output-two.
// RULE7 - Loopback bit enables local loopback; clearing returns to normal.
// RULE8 - Any-character resume restarts transmitter; flow characters are not stored.
// RULE9 - Infrared bit routes serial data through codec; idle output low.
// RULE10 - Prescaler bit divides the baud clock by four.
// RULE11 - Overrun interrupts at once; character errors when at holding position.
// RULE12 - Data ready shows one while any received character is held.
// RULE13 - Overrun on full receive FIFO; no transfer, FIFO untouched.
// RULE14 - Parity flag follows the character at the holding position.
// RULE15 - Framing flag follows the character at the holding position.
// RULE16 - Low line for a whole frame flags break, stores one character.
// RULE17 - Holding-empty sets on move or empty FIFO, clears on host write.
// RULE18 - Transmitter-empty high only when holding and shifter are empty.
// RULE19 - FIFO error flag is the OR of all stored error tags.
// RULE20 - Modem change bits latch; clear-to-send/set-ready changes request interrupts.
// RULE21 - Software should not write the two status registers.
// RULE22 - Ring change flag sets only at end of ringing.
// RULE23 - Carrier change flag sets on any carrier change.
// RULE24 - Upper modem status bits show inputs, or control bits in loopback.
// RULE25 - Reading modem status clears changes; reading line status clears overrun.
// RULE26 - Loopback feeds output to receiver, idles pin and modem outputs.
package ulm_pkg;
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IER  = 3'h1;
  localparam logic [2:0] ADR_LCR  = 3'h3;
  localparam logic [2:0] ADR_MCR  = 3'h4;
  localparam logic [2:0] ADR_LSR  = 3'h5;
  localparam logic [2:0] ADR_MSR  = 3'h6;
  localparam int LCR_BRK = 6;
  localparam int LCR_DLAB = 7;
  localparam int LCR_PAR = 3;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_IRQEN = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_ANY = 5;
  localparam int MCR_IR = 6;
  localparam int MCR_PRE = 7;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [3:0] FRAME_BASE = 4'h7;
  // Sync reset: rx and modem pins idle high; select low.
  localparam logic [5:0] SYNC_RST = 6'h1f;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ulm_modem_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
  } ulm_rx_tag_t;
endpackage

// file: rtl/ulm_sync3.sv
// Purpose: Three-stage synchroniser bank for pins from outside the clock.
// Assumes: Slow level inputs; one clock.
// Notes: A bit counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ulm_sync3 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          s1_r <= RST[g];
          s2_r <= RST[g];
          s3_r <= RST[g];
          o_sync[g] <= RST[g];
        end else begin
          s1_r <= i_async[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            o_sync[g] <= s3_r;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/ulm_ctrl.sv
// Purpose: Line control, modem control and status logic of one channel.
// Assumes: Shifters, FIFOs and baud generator sit outside.
// Notes: Read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic [2:0]         i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output var  logic [7:0]         o_rdata,
  input  wire logic               i_enh_en,
  input  wire logic [7:0]         i_rx_data,
  input  wire logic               i_rx_nonempty,
  input  wire ulm_pkg::ulm_rx_tag_t i_rx_head_tag,
  input  wire logic               i_rx_tag_any,
  input  wire logic               i_rx_done,
  input  wire logic               i_rx_fifo_full,
  input  wire logic               i_rx_flow_char,
  input  wire logic               i_swfc_active,
  input  wire logic               i_tx_halted,
  input  wire logic               i_fifo_mode,
  input  wire logic               i_tx_load,
  input  wire logic               i_tx_fifo_empty,
  input  wire logic               i_tsr_empty,
  input  wire logic               i_tx_serial,
  input  wire logic               i_ir_tx,
  input  wire logic               i_ir_rx,
  input  wire logic               i_bit_tick,
  input  wire logic               i_auto_rts,
  input  wire logic               i_auto_rts_n,
  input  wire logic               i_irq_pending,
  input  wire logic               i_rx_pin,
  input  wire logic               i_cts_n,
  input  wire logic               i_dsr_n,
  input  wire logic               i_ri_n,
  input  wire logic               i_cd_n,
  input  wire logic               i_irq_drive_select,
  output var  logic               o_tx_pin,
  output var  logic               o_rx_serial,
  output var  logic               o_dtr_n,
  output var  logic               o_rts_n,
  output var  logic               o_irq,
  output var  logic               o_irq_oe_n,
  output var  logic               o_ls_irq_req,
  output var  logic               o_ms_irq_req,
  output var  logic               o_tx_wr,
  output var  logic [7:0]         o_tx_data,
  output var  logic               o_rx_pop,
  output var  logic               o_rx_push,
  output var  logic               o_rx_push_break,
  output var  logic               o_tx_resume,
  output var  logic               o_baud_clk_en,
  output var  logic [15:0]        o_divisor,
  output var  logic               o_loop_output_two_n,
  output var  logic               o_ir_enable
);
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] ier_r;
  logic [7:0] dll_r;
  logic [7:0] dlm_r;
  logic [5:0] pins_s;
  logic       rx_pin_s;
  logic       irq_sel_s;
  ulm_pkg::ulm_modem_t pin_act;
  ulm_pkg::ulm_modem_t mdm_now;
  ulm_pkg::ulm_modem_t mdm_prev_r;
  ulm_pkg::ulm_modem_t delta_r;
  ulm_pkg::ulm_modem_t delta_set;
  logic       overrun_r;
  logic       thr_empty_r;
  logic       brk_line_r;
  logic [3:0] low_cnt_r;
  logic [3:0] frame_bits;
  logic [1:0] pre_cnt_r;
  logic       loop_en;
  logic       dlab;
  logic       wr_data;
  logic       rd_lsr;
  logic       rd_msr;
  logic       line_in;
  logic       tx_int;
  logic       overrun_set;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [7:0] rd_mux;

  ulm_sync3 #(
    .W   (6),
    .RST (ulm_pkg::SYNC_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_irq_drive_select, i_cd_n, i_ri_n, i_dsr_n, i_cts_n,
               i_rx_pin}),
    .o_sync  (pins_s)
  );
  assign rx_pin_s  = pins_s[0];
  assign irq_sel_s = pins_s[5];

  assign loop_en = mcr_r[ulm_pkg::MCR_LOOP];  // [RULE7]
  assign dlab    = lcr_r[ulm_pkg::LCR_DLAB];
  assign wr_data = i_wr && (i_addr == ulm_pkg::ADR_DATA) && !dlab;  // [RULE2]
  assign rd_lsr  = i_rd && (i_addr == ulm_pkg::ADR_LSR);
  assign rd_msr  = i_rd && (i_addr == ulm_pkg::ADR_MSR);

  // Register writes.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lcr_r <= ulm_pkg::REG_RST;
      mcr_r <= ulm_pkg::REG_RST;
      ier_r <= ulm_pkg::REG_RST;
      dll_r <= ulm_pkg::REG_RST;
      dlm_r <= ulm_pkg::REG_RST;
    end else if (i_wr) begin
      if (i_addr == ulm_pkg::ADR_DATA && dlab) begin
        dll_r <= i_wdata;  // [RULE2]
      end else if (i_addr == ulm_pkg::ADR_IER && dlab) begin
        dlm_r <= i_wdata;  // [RULE2]
      end else if (i_addr == ulm_pkg::ADR_IER) begin
        ier_r <= i_wdata;
      end else if (i_addr == ulm_pkg::ADR_LCR) begin
        lcr_r <= i_wdata;
      end else if (i_addr == ulm_pkg::ADR_MCR) begin
        // Upper bits are locked unless the enhanced enable is on.
        if (i_enh_en) begin
          mcr_r <= i_wdata;
        end else begin
          mcr_r <= (mcr_r & ulm_pkg::MCR_ENH_MASK) |
                   (i_wdata & ~ulm_pkg::MCR_ENH_MASK);
        end
      end
    end
  end

  // Strobes toward the transmit and receive FIFOs.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_wr   <= 1'b0;
      o_tx_data <= ulm_pkg::REG_RST;
      o_rx_pop  <= 1'b0;
      o_divisor <= {ulm_pkg::REG_RST, ulm_pkg::REG_RST};
    end else begin
      o_tx_wr  <= wr_data;
      o_rx_pop <= i_rd && (i_addr == ulm_pkg::ADR_DATA) && !dlab;  // [RULE2]
      if (wr_data) begin
        o_tx_data <= i_wdata;
      end
      o_divisor <= {dlm_r, dll_r};
    end
  end

  // Receive input: loopback takes the internal serial stream.
  assign tx_int  = lcr_r[ulm_pkg::LCR_BRK] ? 1'b0 : i_tx_serial;  // [RULE1]
  assign line_in = loop_en ? tx_int :
                   (mcr_r[ulm_pkg::MCR_IR] ? i_ir_rx : rx_pin_s);  // [RULE9]

  // Serial pin and modem output drivers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_pin            <= 1'b1;
      o_rx_serial         <= 1'b1;
      o_dtr_n             <= 1'b1;
      o_rts_n             <= 1'b1;
      o_loop_output_two_n <= 1'b1;
      o_ir_enable         <= 1'b0;
    end else begin
      o_rx_serial <= line_in;  // [RULE26]
      o_ir_enable <= mcr_r[ulm_pkg::MCR_IR];
      if (loop_en) begin
        o_tx_pin <= 1'b1;  // [RULE26]
      end else if (lcr_r[ulm_pkg::LCR_BRK]) begin
        o_tx_pin <= 1'b0;  // [RULE1]
      end else if (mcr_r[ulm_pkg::MCR_IR]) begin
        o_tx_pin <= i_ir_tx;  // [RULE9]
      end else begin
        o_tx_pin <= i_tx_serial;
      end
      o_dtr_n <= loop_en ? 1'b1 : ~mcr_r[ulm_pkg::MCR_DTR];  // [RULE3]
      if (loop_en) begin
        o_rts_n <= 1'b1;  // [RULE26]
      end else if (i_auto_rts) begin
        o_rts_n <= i_auto_rts_n;  // [RULE4]
      end else begin
        o_rts_n <= ~mcr_r[ulm_pkg::MCR_RTS];  // [RULE4]
      end
      o_loop_output_two_n <= ~mcr_r[ulm_pkg::MCR_IRQEN];  // [RULE6]
    end
  end

  // Interrupt pin: driven when the select pin or enable bit is high.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq      <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else begin
      o_irq      <= i_irq_pending;
      o_irq_oe_n <= !(irq_sel_s || mcr_r[ulm_pkg::MCR_IRQEN]);  // [RULE5]
    end
  end

  // Baud clock prescaler: every cycle, or every fourth.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt_r     <= 2'h0;
      o_baud_clk_en <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
      if (mcr_r[ulm_pkg::MCR_PRE]) begin
        o_baud_clk_en <= (pre_cnt_r == ulm_pkg::PRE_LAST);  // [RULE10]
      end else begin
        o_baud_clk_en <= 1'b1;  // [RULE10]
      end
    end
  end

  // Receive character routing, overrun and any-character resume.
  assign overrun_set = i_rx_done && i_rx_fifo_full;  // [RULE13]
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_push   <= 1'b0;
      o_tx_resume <= 1'b0;
    end else begin
      // A full FIFO takes nothing, so its contents stay intact.
      o_rx_push <= i_rx_done && !i_rx_fifo_full &&
                   !(mcr_r[ulm_pkg::MCR_ANY] && i_swfc_active &&
                     i_rx_flow_char);  // [RULE8] [RULE13]
      o_tx_resume <= i_rx_done && mcr_r[ulm_pkg::MCR_ANY] &&
                     i_tx_halted;  // [RULE8]
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      overrun_r <= 1'b0;
    end else if (overrun_set) begin
      overrun_r <= 1'b1;  // [RULE13]
    end else if (rd_lsr) begin
      overrun_r <= 1'b0;  // [RULE25]
    end else if (i_wr && i_addr == ulm_pkg::ADR_LSR) begin
      overrun_r <= i_wdata[1];
    end
  end

  // Break: bit ticks counted while the line is low.
  // Frame is start, 5 to 8 data bits, optional parity and one stop.
  assign frame_bits = ulm_pkg::FRAME_BASE + {2'h0, lcr_r[1:0]} +
                      {3'h0, lcr_r[ulm_pkg::LCR_PAR]};
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt_r       <= 4'h0;
      brk_line_r      <= 1'b0;
      o_rx_push_break <= 1'b0;
    end else begin
      o_rx_push_break <= 1'b0;
      if (line_in) begin
        low_cnt_r  <= 4'h0;
        brk_line_r <= 1'b0;  // [RULE16]
      end else if (i_bit_tick && !brk_line_r) begin
        if (low_cnt_r + 4'h1 >= frame_bits) begin
          // One break character only, however long the line stays low.
          brk_line_r      <= 1'b1;  // [RULE16]
          o_rx_push_break <= !i_rx_fifo_full;  // [RULE16]
        end else begin
          low_cnt_r <= low_cnt_r + 4'h1;
        end
      end
    end
  end

  // Host write beats a load: the byte enters holding.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thr_empty_r <= 1'b1;
    end else if (wr_data) begin
      thr_empty_r <= 1'b0;  // [RULE17]
    end else if (i_fifo_mode) begin
      thr_empty_r <= i_tx_fifo_empty;  // [RULE17]
    end else if (i_tx_load) begin
      thr_empty_r <= 1'b1;  // [RULE17]
    end
  end

  always_comb begin
    lsr_val    = 8'h00;
    lsr_val[0] = i_rx_nonempty;  // [RULE12]
    lsr_val[1] = overrun_r;
    lsr_val[2] = i_rx_head_tag.parity;  // [RULE14]
    lsr_val[3] = i_rx_head_tag.framing;  // [RULE15]
    lsr_val[4] = i_rx_head_tag.brk || brk_line_r;  // [RULE16]
    lsr_val[5] = thr_empty_r;
    lsr_val[6] = thr_empty_r && i_tsr_empty;  // [RULE18]
    lsr_val[7] = i_rx_tag_any;  // [RULE19]
  end

  // Modem inputs, active high, or the control bits in loopback.
  assign pin_act = ~pins_s[4:1];
  always_comb begin
    if (loop_en) begin
      mdm_now.cts = mcr_r[ulm_pkg::MCR_RTS];  // [RULE24]
      mdm_now.dsr = mcr_r[ulm_pkg::MCR_DTR];  // [RULE24]
      mdm_now.ri  = mcr_r[ulm_pkg::MCR_OUT1];  // [RULE6] [RULE24]
      mdm_now.cd  = mcr_r[ulm_pkg::MCR_IRQEN];  // [RULE24]
    end else begin
      mdm_now = pin_act;  // [RULE24]
    end
    delta_set.cts = mdm_now.cts != mdm_prev_r.cts;  // [RULE20]
    delta_set.dsr = mdm_now.dsr != mdm_prev_r.dsr;  // [RULE20]
    delta_set.ri  = mdm_prev_r.ri && !mdm_now.ri;  // [RULE22]
    delta_set.cd  = mdm_now.cd != mdm_prev_r.cd;  // [RULE23]
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mdm_prev_r <= '0;
      delta_r    <= '0;
    end else begin
      mdm_prev_r <= mdm_now;
      if (rd_msr) begin
        delta_r <= delta_set;  // [RULE25]
      end else if (i_wr && i_addr == ulm_pkg::ADR_MSR) begin
        delta_r <= i_wdata[3:0] | delta_set;
      end else begin
        delta_r <= delta_r | delta_set;  // [RULE20]
      end
    end
  end
  assign msr_val = {mdm_now, delta_r};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ls_irq_req <= 1'b0;
      o_ms_irq_req <= 1'b0;
    end else begin
      o_ls_irq_req <= ier_r[ulm_pkg::IER_LS] &&
                      (overrun_r || overrun_set ||
                       (|i_rx_head_tag));  // [RULE11]
      o_ms_irq_req <= ier_r[ulm_pkg::IER_MS] &&
                      (|delta_r);  // [RULE20] [RULE22] [RULE23]
    end
  end

  always_comb begin
    if (i_addr == ulm_pkg::ADR_DATA) begin
      rd_mux = dlab ? dll_r : i_rx_data;  // [RULE2]
    end else if (i_addr == ulm_pkg::ADR_IER) begin
      rd_mux = dlab ? dlm_r : ier_r;  // [RULE2]
    end else if (i_addr == ulm_pkg::ADR_LCR) begin
      rd_mux = lcr_r;
    end else if (i_addr == ulm_pkg::ADR_MCR) begin
      rd_mux = mcr_r;
    end else if (i_addr == ulm_pkg::ADR_LSR) begin
      rd_mux = lsr_val;
    end else if (i_addr == ulm_pkg::ADR_MSR) begin
      rd_mux = msr_val;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// file: sim/ulm_ctrl_sva.sv
// Purpose: Port assertions for the control block.
// Assumes: Register mirrors follow host writes.
// Notes: Pin outputs are judged once a mirror stood a cycle.
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl_sva (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_enh_en,
  input wire logic       i_rx_done,
  input wire logic       i_rx_fifo_full,
  input wire logic       o_rx_push,
  input wire logic       o_tx_wr,
  input wire logic       o_tx_pin,
  input wire logic       o_dtr_n,
  input wire logic       o_ls_irq_req,
  input wire logic       o_baud_clk_en,
  input wire logic       o_loop_output_two_n,
  input wire logic       o_ir_enable
);
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] ier_r;

  // Upper control bits need the enhanced enable.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lcr_r <= 8'h00;
      mcr_r <= 8'h00;
      ier_r <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == 3'h3) lcr_r <= i_wdata;
      if (i_addr == 3'h4) mcr_r <= {i_enh_en ? i_wdata[7:5] : mcr_r[7:5],
                                    i_wdata[4:0]};
      if (i_addr == 3'h1 && !lcr_r[7]) ier_r <= i_wdata;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_brk;
    $stable(lcr_r) && $stable(mcr_r) && lcr_r[6] && !mcr_r[4] |-> !o_tx_pin;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break not low");

  property p_dlab;
    o_tx_wr |-> $past(i_wr) && $past(i_addr) == 3'h0 && !$past(lcr_r[7]);
  endproperty
  a_dlab: assert property (p_dlab)
    else $error("stray tx write");

  property p_dtr;
    $stable(mcr_r) && !mcr_r[4] |-> o_dtr_n == !mcr_r[0];
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("dtr mismatch");

  property p_op2;
    $stable(mcr_r) |-> o_loop_output_two_n == !mcr_r[3];
  endproperty
  a_op2: assert property (p_op2)
    else $error("op2 mismatch");

  property p_ir;
    $stable(mcr_r) |-> o_ir_enable == mcr_r[6];
  endproperty
  a_ir: assert property (p_ir)
    else $error("ir mismatch");

  property p_pre;
    o_baud_clk_en && mcr_r[7] && $past(mcr_r[7])
      |=> !o_baud_clk_en [*3] ##1 o_baud_clk_en;
  endproperty
  a_pre: assert property (p_pre)
    else $error("prescale wrong");

  property p_lsirq;
    i_rx_done && i_rx_fifo_full && ier_r[2] |-> ##[1:2] o_ls_irq_req;
  endproperty
  a_lsirq: assert property (p_lsirq)
    else $error("no overrun irq");

  property p_ovr;
    i_rx_done && i_rx_fifo_full |=> !o_rx_push;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("push when full");

  property p_loop;
    $stable(mcr_r) && mcr_r[4] |-> o_tx_pin && o_dtr_n;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop pins busy");
endmodule

bind ulm_ctrl ulm_ctrl_sva u_sva (.*);
`default_nettype wire

// file: sim/ulm_modem_model.sv
// Purpose: Remote modem partner of the control block.
// Assumes: Lines rest high when idle.
// Notes: A change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ulm_modem_model (
  input  wire logic                i_clk,
  output var  logic                o_rx_pin,
  output var  ulm_pkg::ulm_modem_t o_lines_n
);
  initial begin
    o_rx_pin = 1'b1;
    o_lines_n = 4'hf;
  end
  // A long low on the data line sends a break.
  task automatic drive(input logic rx, input logic [3:0] lines_n);
    @(posedge i_clk);
    o_rx_pin <= rx;
    o_lines_n <= lines_n;
  endtask
endmodule
`default_nettype wire

// file: sim/uart_line_modem_ctrl_status_tb_top.sv
// Purpose: Self-checking bench for the control block.
// Assumes: Host strobes change just after an edge.
// Notes: The bench drives the FIFO side inputs.
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_ctrl_status_tb_top;
  logic        i_clk = 1'b0, i_rstn = 1'b0;
  logic [2:0]  i_addr = 3'h0;
  logic [7:0]  i_wdata = 8'h00, i_rx_data = 8'h00;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_enh_en = 1'b1;
  logic        i_rx_nonempty = 1'b0, i_rx_tag_any = 1'b0, i_rx_done = 1'b0;
  ulm_pkg::ulm_rx_tag_t i_rx_head_tag = 3'h0;
  logic        i_rx_fifo_full = 1'b0, i_rx_flow_char = 1'b0;
  logic        i_swfc_active = 1'b0, i_tx_halted = 1'b0, i_fifo_mode = 1'b0;
  logic        i_tx_load = 1'b0, i_tx_fifo_empty = 1'b1, i_tsr_empty = 1'b1;
  logic        i_tx_serial = 1'b1, i_ir_tx = 1'b1, i_ir_rx = 1'b1;
  logic        i_bit_tick = 1'b0, i_auto_rts = 1'b0, i_auto_rts_n = 1'b0;
  logic        i_irq_pending = 1'b0, i_irq_drive_select = 1'b0;
  wire logic   i_rx_pin, i_cts_n, i_dsr_n, i_ri_n, i_cd_n;
  ulm_pkg::ulm_modem_t lines_n;
  logic [7:0]  o_rdata, o_tx_data;
  logic [15:0] o_divisor;
  logic        o_tx_pin, o_rx_serial, o_dtr_n, o_rts_n, o_irq, o_irq_oe_n;
  logic        o_ls_irq_req, o_ms_irq_req, o_tx_wr, o_rx_pop, o_rx_push;
  logic        o_rx_push_break, o_tx_resume, o_baud_clk_en;
  logic        o_loop_output_two_n, o_ir_enable;
  int          error_cnt = 0, checks = 0, brk_cnt = 0, clk_en_cnt = 0;
  localparam logic [3:0] LN [5] = '{4'he, 4'ha, 4'he, 4'h6, 4'h4};
  localparam logic [7:0] MS [5] = '{8'h11, 8'h50, 8'h14, 8'h98, 8'hb2};
  localparam logic [4:0] MS_IRQ = 5'b11101;

  assign {i_cd_n, i_ri_n, i_dsr_n, i_cts_n} = lines_n;
  ulm_ctrl u_dut (.*);
  ulm_modem_model u_modem (.i_clk(i_clk), .o_rx_pin(i_rx_pin),
                           .o_lines_n(lines_n));

  initial begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_rx_push_break === 1'b1) brk_cnt++;
    if (o_baud_clk_en === 1'b1) clk_en_cnt++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Status registers are only ever read from here.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, m);
    logic [7:0] d;
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata & m;
    chk($sformatf("reg %0h", a), {8'h00, e & m}, {8'h00, d});
  endtask
  task automatic rx_char(input logic e_push, e_res);
    @(posedge i_clk);
    i_rx_done <= 1'b1;
    @(posedge i_clk);
    i_rx_done <= 1'b0;
    #1 chk_bit("rx_push", e_push, o_rx_push);
    chk_bit("tx_resume", e_res, o_tx_resume);
  endtask
  task automatic finish_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Tests take under 1,000 cycles; allow ten times.
  initial begin
    #80000;
    error_cnt++;
    finish_test();
  end

  initial begin
    tick(16);
    i_rstn <= 1'b1;
    chk_bit("dtr_n", 1'b1, o_dtr_n);
    chk_bit("rts_n", 1'b1, o_rts_n);
    chk_bit("irq_oe_n", 1'b1, o_irq_oe_n);
    chk_rd(3'h3, 8'h00, 8'hff);
    chk_rd(3'h4, 8'h00, 8'hff);
    chk_rd(3'h5, 8'h60, 8'hff);
    chk_rd(3'h6, 8'h00, 8'hff);
    chk_rd(3'h2, 8'h00, 8'hff);
    $display("test reset done");
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk_rd(3'h0, 8'h34, 8'hff);
    chk("divisor", 16'h1234, o_divisor);
    wr(3'h3, 8'h03);
    wr(3'h0, 8'h5a);
    i_tsr_empty <= 1'b0;
    #1 chk_bit("tx_wr", 1'b1, o_tx_wr);
    chk("tx_data", 16'h005a, {8'h00, o_tx_data});
    chk_rd(3'h5, 8'h00, 8'hff);
    @(posedge i_clk) i_tx_load <= 1'b1;
    @(posedge i_clk) i_tx_load <= 1'b0;
    chk_rd(3'h5, 8'h20, 8'hff);
    @(posedge i_clk) {i_tsr_empty, i_fifo_mode, i_tx_fifo_empty} <= 3'h6;
    chk_rd(3'h5, 8'h00, 8'hff);
    @(posedge i_clk) {i_fifo_mode, i_tx_fifo_empty} <= 2'b11;
    chk_rd(3'h5, 8'h60, 8'hff);
    $display("test divisor and transmit done");
    wr(3'h4, 8'h03);
    tick(2);
    {i_auto_rts, i_auto_rts_n} <= 2'b11;
    #1 chk_bit("dtr_n", 1'b0, o_dtr_n);
    chk_bit("rts_n", 1'b0, o_rts_n);
    tick(2);
    i_auto_rts <= 1'b0;
    #1 chk_bit("rts_n", 1'b1, o_rts_n);
    wr(3'h3, 8'h43);
    tick(2);
    #1 chk_bit("tx_pin", 1'b0, o_tx_pin);
    wr(3'h3, 8'h03);
    tick(2);
    #1 chk_bit("tx_pin", 1'b1, o_tx_pin);
    wr(3'h4, 8'h08);
    i_irq_pending <= 1'b1;
    tick(2);
    #1 chk_bit("irq_oe_n", 1'b0, o_irq_oe_n);
    chk_bit("irq", 1'b1, o_irq);
    wr(3'h4, 8'h00);
    tick(2);
    i_irq_drive_select <= 1'b1;
    #1 chk_bit("irq_oe_n", 1'b1, o_irq_oe_n);
    tick(8);
    i_irq_drive_select <= 1'b0;
    #1 chk_bit("irq_oe_n", 1'b0, o_irq_oe_n);
    $display("test modem outputs done");
    wr(3'h4, 8'h1b);
    tick(2);
    i_tx_serial <= 1'b0;
    #1 chk_bit("tx_pin", 1'b1, o_tx_pin);
    chk_bit("dtr_n", 1'b1, o_dtr_n);
    chk_bit("op2_n", 1'b0, o_loop_output_two_n);
    chk_rd(3'h6, 8'hb0, 8'hf0);
    chk_bit("rx_serial", 1'b0, o_rx_serial);
    wr(3'h4, 8'h00);
    i_tx_serial <= 1'b1;
    tick(8);
    chk_rd(3'h6, 8'h00, 8'hf0);
    chk_rd(3'h6, 8'h00, 8'hff);
    $display("test loopback done");
    wr(3'h1, 8'h08);
    for (int k = 0; k < 5; k++) begin
      u_modem.drive(1'b1, LN[k]);
      tick(8);
      #1 chk_bit("ms_irq", MS_IRQ[k], o_ms_irq_req);
      chk_rd(3'h6, MS[k], 8'hff);
    end
    u_modem.drive(1'b1, 4'hf);
    tick(8);
    chk_rd(3'h6, 8'h0b, 8'hff);
    wr(3'h1, 8'h04);
    $display("test modem status done");
    @(posedge i_clk) {i_rx_nonempty, i_rx_head_tag, i_rx_tag_any} <= 5'h1f;
    chk_rd(3'h5, 8'hfd, 8'hff);
    @(posedge i_clk) {i_rx_nonempty, i_rx_head_tag, i_rx_tag_any} <= 5'h00;
    chk_rd(3'h5, 8'h60, 8'hff);
    @(posedge i_clk) i_rx_fifo_full <= 1'b1;
    rx_char(1'b0, 1'b0);
    tick(1);
    #1 chk_bit("ls_irq", 1'b1, o_ls_irq_req);
    chk_rd(3'h5, 8'h62, 8'hff);
    chk_rd(3'h5, 8'h60, 8'hff);
    @(posedge i_clk) i_rx_fifo_full <= 1'b0;
    rx_char(1'b1, 1'b0);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h20);
    i_tx_halted <= 1'b1;
    rx_char(1'b1, 1'b1);
    @(posedge i_clk) {i_swfc_active, i_rx_flow_char} <= 2'b11;
    rx_char(1'b0, 1'b1);
    @(posedge i_clk) {i_swfc_active, i_rx_flow_char, i_tx_halted} <= 3'h0;
    $display("test receive status done");
    wr(3'h4, 8'h40);
    i_ir_tx <= 1'b0;
    tick(2);
    #1 chk_bit("ir_en", 1'b1, o_ir_enable);
    chk_bit("tx_pin", 1'b0, o_tx_pin);
    wr(3'h4, 8'h00);
    i_enh_en <= 1'b0;
    wr(3'h4, 8'he0);
    chk_rd(3'h4, 8'h00, 8'hff);
    u_modem.drive(1'b0, 4'hf);
    tick(6);
    #1 brk_cnt = 0;
    repeat (12) begin
      @(posedge i_clk) i_bit_tick <= 1'b1;
      @(posedge i_clk) i_bit_tick <= 1'b0;
    end
    tick(2);
    #1 chk("brk_push", 16'h0001, brk_cnt[15:0]);
    chk_rd(3'h5, 8'h10, 8'h10);
    u_modem.drive(1'b1, 4'hf);
    tick(8);
    chk_rd(3'h5, 8'h00, 8'h10);
    $display("test infrared and break done");
    @(posedge i_clk) i_enh_en <= 1'b1;
    wr(3'h4, 8'h80);
    tick(4);
    #1 clk_en_cnt = 0;
    tick(40);
    #1 chk("baud_en", 16'h000a, clk_en_cnt[15:0]);
    $display("test prescaler done");
    finish_test();
  end
endmodule
`default_nettype wire
